/* shared/swt_pkg.sv */
/*
 * swt_pkg: register offsets, field positions, reset values and timing counts
 * for the sleep wakeup timer block.
 * assumes: apb with 32-bit data, one aligned word per register.
 */
package swt_pkg;
    localparam int          SWT_CNT_W         = 41;
    localparam int          SWT_REF_W         = 32;
    localparam int          SWT_NUM_TMR       = 2;

    localparam logic [7:0]  SWT_OFF_CTRL      = 8'h00;
    localparam logic [7:0]  SWT_OFF_STATUS    = 8'h04;
    localparam logic [7:0]  SWT_OFF_LOAD0_LO  = 8'h08;
    localparam logic [7:0]  SWT_OFF_LOAD0_HI  = 8'h0c;
    localparam logic [7:0]  SWT_OFF_LOAD1_LO  = 8'h10;
    localparam logic [7:0]  SWT_OFF_LOAD1_HI  = 8'h14;
    localparam logic [7:0]  SWT_OFF_CNT0_LO   = 8'h18;
    localparam logic [7:0]  SWT_OFF_CNT0_HI   = 8'h1c;
    localparam logic [7:0]  SWT_OFF_CNT1_LO   = 8'h20;
    localparam logic [7:0]  SWT_OFF_CNT1_HI   = 8'h24;
    localparam logic [7:0]  SWT_OFF_CMD       = 8'h28;
    localparam logic [7:0]  SWT_OFF_CALREF    = 8'h2c;

    // ctrl fields
    localparam int          SWT_CTRL_IEN0     = 0;
    localparam int          SWT_CTRL_IEN1     = 1;
    localparam int          SWT_CTRL_SLPDIS   = 2;
    localparam int          SWT_CTRL_SRC_LSB  = 4;
    localparam logic [31:0] SWT_CTRL_RESET    = 32'h0000_0000;
    localparam logic [31:0] SWT_CTRL_MASK     = 32'h0000_0037;

    // cmd fields (write-only strobes)
    localparam int          SWT_CMD_START0    = 0;
    localparam int          SWT_CMD_START1    = 1;
    localparam int          SWT_CMD_STOP0     = 2;
    localparam int          SWT_CMD_STOP1     = 3;
    localparam int          SWT_CMD_CAL       = 4;

    // status fields
    localparam int          SWT_ST_RUN_LSB    = 0;
    localparam int          SWT_ST_EXP_LSB    = 2;
    localparam int          SWT_ST_CALBUSY    = 4;

    localparam logic [1:0]  SWT_SRC_RC        = 2'h0;
    localparam logic [1:0]  SWT_SRC_XTAL      = 2'h1;
    localparam logic [1:0]  SWT_SRC_EXT       = 2'h2;

    // nominal calibration figures
    localparam int          SWT_SYS_HZ        = 16000000;
    localparam int          SWT_RC_HZ         = 32000;
    localparam int          SWT_CAL_PERIODS   = 20;
    localparam int          SWT_CAL_NOMINAL   = SWT_SYS_HZ / SWT_RC_HZ * SWT_CAL_PERIODS;

    typedef enum logic [1:0] {SWT_PWR_AWAKE, SWT_PWR_SLEEP, SWT_PWR_DEEP} swt_pwr_t;

    typedef struct packed {
        logic [1:0] run;
        logic [1:0] exp;
        logic       cal_busy;
    } swt_status_t;
endpackage

/* rtl/swt_edge_sync.sv */
/*
 * swt_edge_sync: two-flop synchroniser on a slow clock pin and a one-cycle
 * rising edge pulse.
 * assumes: source clock well below pclk, so no edge is lost.
 */
`timescale 1ns/1ps
`default_nettype none
module swt_edge_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output logic      rise_pulse
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;
    logic rise_next;

    always_comb begin
        rise_next = sync_reg & ~last_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg   <= 1'b0;
            sync_reg   <= 1'b0;
            last_reg   <= 1'b0;
            rise_pulse <= 1'b0;
        end else begin
            meta_reg   <= async_in;
            sync_reg   <= meta_reg;
            last_reg   <= sync_reg;
            rise_pulse <= rise_next;
        end
    end
endmodule
`default_nettype wire

/* rtl/swt_top.sv */
/*
 * swt_top: two 41-bit wakeup down-counters ticked by a selected 32 kHz source,
 * an apb register slave and a calibration reference counter on pclk.
 * assumes: pclk is the system clock; the 32 kHz clocks arrive as pins from
 * outside the pclk domain; the power state comes from the power controller.
 */
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
//Contract
//- two independent 41-bit down-counters, one step per selected 32 kHz period
//- 32 kHz source chosen from rc oscillator, crystal or external clock
//- running timer reaching zero flags expiry; interrupt raised when enabled
//- after zero the timer keeps counting down, wrapping, until stopped
//- load and start makes counting begin from loaded value on later ticks
//- stop halts the timer anytime, holds value, no event afterwards
//- status shows running and expired; reading it clears expired flags
//- timers run in sleep unless disabled for sleep; never in deep sleep
//- enabled expiry during sleep acts as a wake source
//- reference counter counts system clocks while awake
//- during calibration reference runs until timer 0 hits zero, then holds
//- 32000 Hz rc over twenty periods yields a reference count of 10000
module swt_top
    import swt_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        clk32_rc,
    input  wire logic        clk32_xtal,
    input  wire logic        clk32_ext,
    input  wire logic [1:0]  pwr_state,
    output logic      [1:0]  tmr_irq,
    output logic             wake_req
);
    logic [2:0]           src_tick;
    logic                 tick;
    logic [31:0]          ctrl_reg,  ctrl_next;
    logic [SWT_CNT_W-1:0] load_reg  [SWT_NUM_TMR], load_next [SWT_NUM_TMR];
    logic [SWT_CNT_W-1:0] cnt_reg   [SWT_NUM_TMR], cnt_next  [SWT_NUM_TMR];
    logic [1:0]           run_reg,   run_next;
    logic [1:0]           exp_reg,   exp_next;
    logic                 cal_reg,   cal_next;
    logic [SWT_REF_W-1:0] ref_reg,   ref_next;
    logic [31:0]          prdata_next;
    logic                 pslverr_next;
    logic [1:0]           irq_next;
    logic                 wake_next;
    logic                 wr, rd, tick_en;
    logic [1:0]           hit;
    swt_status_t          st;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            swt_edge_sync i_swt_edge_sync (
                .pclk       (pclk),
                .presetn    (presetn),
                .async_in   (g == 0 ? clk32_rc : (g == 1 ? clk32_xtal : clk32_ext)),
                .rise_pulse (src_tick[g])
            );
        end
    endgenerate

    function automatic logic valid_off(input logic [7:0] a);
        valid_off = (a <= SWT_OFF_CALREF) && (a[1:0] == 2'h0);
    endfunction

    always_comb begin
        case (ctrl_reg[SWT_CTRL_SRC_LSB +: 2])
            SWT_SRC_RC:   tick = src_tick[0];
            SWT_SRC_XTAL: tick = src_tick[1];
            SWT_SRC_EXT:  tick = src_tick[2];
            default:      tick = src_tick[0];
        endcase
    end

    always_comb begin
        wr = psel & penable & pwrite;
        rd = psel & penable & ~pwrite;
        case (pwr_state)
            SWT_PWR_AWAKE: tick_en = tick;
            SWT_PWR_SLEEP: tick_en = tick & ~ctrl_reg[SWT_CTRL_SLPDIS];
            default:       tick_en = 1'b0;
        endcase
    end

    always_comb begin
        ctrl_next = ctrl_reg;
        run_next  = run_reg;
        exp_next  = exp_reg;
        cal_next  = cal_reg;
        ref_next  = ref_reg;
        hit       = 2'b00;
        for (int i = 0; i < SWT_NUM_TMR; i++) begin
            load_next[i] = load_reg[i];
            cnt_next[i]  = cnt_reg[i];
        end
        // a status read clears only the expiry bits it reported, so a hit between setup and access is not lost
        if (rd && paddr == SWT_OFF_STATUS) begin
            exp_next = exp_reg & ~prdata[SWT_ST_EXP_LSB +: 2];
        end
        for (int i = 0; i < SWT_NUM_TMR; i++) begin
            if (run_reg[i] && tick_en) begin
                cnt_next[i] = cnt_reg[i] - 41'h1;
                if (cnt_reg[i] == 41'h1) begin
                    hit[i]      = 1'b1;
                    exp_next[i] = 1'b1;
                end
            end
        end
        if (cal_reg && pwr_state == SWT_PWR_AWAKE) begin
            ref_next = ref_reg + 32'h1;
        end
        if (cal_reg && hit[0]) begin
            cal_next = 1'b0;
        end
        if (wr) begin
            case (paddr)
                SWT_OFF_CTRL:     ctrl_next = pwdata & SWT_CTRL_MASK;
                SWT_OFF_LOAD0_LO: load_next[0][31:0] = pwdata;
                SWT_OFF_LOAD0_HI: load_next[0][40:32] = pwdata[8:0];
                SWT_OFF_LOAD1_LO: load_next[1][31:0] = pwdata;
                SWT_OFF_LOAD1_HI: load_next[1][40:32] = pwdata[8:0];
                SWT_OFF_CMD: begin
                    for (int i = 0; i < SWT_NUM_TMR; i++) begin
                        if (pwdata[SWT_CMD_START0 + i]) begin
                            cnt_next[i] = load_reg[i];
                            run_next[i] = 1'b1;
                        end
                        if (pwdata[SWT_CMD_STOP0 + i]) begin
                            run_next[i] = 1'b0;
                            hit[i]      = 1'b0;
                            exp_next[i] = exp_reg[i] & ~(rd && paddr == SWT_OFF_STATUS);
                        end
                    end
                    if (pwdata[SWT_CMD_CAL]) begin
                        cal_next    = 1'b1;
                        ref_next    = '0;
                        cnt_next[0] = load_reg[0];
                        run_next[0] = 1'b1;
                    end
                    if (pwdata[SWT_CMD_STOP0]) begin
                        cal_next = 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end

    always_comb begin
        st.run      = run_reg;
        st.exp      = exp_reg;
        st.cal_busy = cal_reg;
        pslverr_next = psel & ~penable & ~valid_off(paddr);
        prdata_next  = 32'h0;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                SWT_OFF_CTRL:     prdata_next = ctrl_reg;
                SWT_OFF_STATUS:   prdata_next = {27'h0, st.cal_busy, st.exp, st.run};
                SWT_OFF_LOAD0_LO: prdata_next = load_reg[0][31:0];
                SWT_OFF_LOAD0_HI: prdata_next = {23'h0, load_reg[0][40:32]};
                SWT_OFF_LOAD1_LO: prdata_next = load_reg[1][31:0];
                SWT_OFF_LOAD1_HI: prdata_next = {23'h0, load_reg[1][40:32]};
                SWT_OFF_CNT0_LO:  prdata_next = cnt_reg[0][31:0];
                SWT_OFF_CNT0_HI:  prdata_next = {23'h0, cnt_reg[0][40:32]};
                SWT_OFF_CNT1_LO:  prdata_next = cnt_reg[1][31:0];
                SWT_OFF_CNT1_HI:  prdata_next = {23'h0, cnt_reg[1][40:32]};
                SWT_OFF_CALREF:   prdata_next = ref_reg;
                default:          prdata_next = 32'h0;
            endcase
        end else if (psel && penable) begin
            prdata_next = prdata;
        end
        irq_next[0] = hit[0] & ctrl_reg[SWT_CTRL_IEN0];
        irq_next[1] = hit[1] & ctrl_reg[SWT_CTRL_IEN1];
        wake_next   = (|irq_next) & (pwr_state == SWT_PWR_SLEEP);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= SWT_CTRL_RESET;
            run_reg  <= 2'b00;
            exp_reg  <= 2'b00;
            cal_reg  <= 1'b0;
            ref_reg  <= '0;
            for (int i = 0; i < SWT_NUM_TMR; i++) begin
                load_reg[i] <= '0;
                cnt_reg[i]  <= '0;
            end
            prdata   <= 32'h0;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            tmr_irq  <= 2'b00;
            wake_req <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            run_reg  <= run_next;
            exp_reg  <= exp_next;
            cal_reg  <= cal_next;
            ref_reg  <= ref_next;
            for (int i = 0; i < SWT_NUM_TMR; i++) begin
                load_reg[i] <= load_next[i];
                cnt_reg[i]  <= cnt_next[i];
            end
            prdata   <= prdata_next;
            pready   <= psel & ~penable;
            pslverr  <= pslverr_next;
            tmr_irq  <= irq_next;
            wake_req <= wake_next;
        end
    end

    // assertions
    a_stop_holds_count: assert property (@(posedge pclk) disable iff (!presetn)
        !run_reg[1] && !(wr && paddr == SWT_OFF_CMD) |=> $stable(cnt_reg[1]))
        else $error("stopped timer count moved");
    a_no_irq_stopped: assert property (@(posedge pclk) disable iff (!presetn)
        !run_reg[0] |=> !tmr_irq[0])
        else $error("irq from stopped timer");
    a_tick_decrements: assert property (@(posedge pclk) disable iff (!presetn)
        run_reg[0] && tick_en && !wr |=> cnt_reg[0] == $past(cnt_reg[0]) - 41'h1)
        else $error("timer did not step down");
    a_wrap_below_zero: assert property (@(posedge pclk) disable iff (!presetn)
        run_reg[0] && tick_en && cnt_reg[0] == 41'h0 && !wr |=> cnt_reg[0] == {SWT_CNT_W{1'b1}})
        else $error("timer did not wrap");
    a_expiry_irq: assert property (@(posedge pclk) disable iff (!presetn)
        hit[0] && ctrl_reg[SWT_CTRL_IEN0] |=> tmr_irq[0] && exp_reg[0])
        else $error("expiry lost");
    a_status_clear: assert property (@(posedge pclk) disable iff (!presetn)
        rd && paddr == SWT_OFF_STATUS && hit == 2'b00 |=> (exp_reg & $past(prdata[SWT_ST_EXP_LSB +: 2])) == 2'b00)
        else $error("status read left expiry set");
    a_deep_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        pwr_state == SWT_PWR_DEEP && !wr |=> $stable(cnt_reg[0]))
        else $error("timer ran in deep sleep");
    a_wake_source: assert property (@(posedge pclk) disable iff (!presetn)
        hit[0] && ctrl_reg[SWT_CTRL_IEN0] && pwr_state == SWT_PWR_SLEEP |=> wake_req)
        else $error("no wake on expiry");
    a_cal_ref_hold: assert property (@(posedge pclk) disable iff (!presetn)
        cal_reg && hit[0] |=> !cal_reg ##1 $stable(ref_reg))
        else $error("reference kept counting");
    a_cal_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == SWT_OFF_CMD && pwdata[SWT_CMD_CAL] |=> ref_reg == '0 && cal_reg)
        else $error("calibration start did not clear");
    a_ref_awake: assert property (@(posedge pclk) disable iff (!presetn)
        cal_reg && pwr_state == SWT_PWR_AWAKE && !wr |=> ref_reg == $past(ref_reg) + 32'h1)
        else $error("reference did not count");
    a_start_load: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == SWT_OFF_CMD && pwdata[SWT_CMD_START1] && !pwdata[SWT_CMD_STOP1]
        |=> run_reg[1] && cnt_reg[1] == $past(load_reg[1]))
        else $error("start did not load");
    a_src_select: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg[SWT_CTRL_SRC_LSB +: 2] == SWT_SRC_EXT && run_reg[0] && pwr_state == SWT_PWR_AWAKE && !wr
        |=> cnt_reg[0] == $past(cnt_reg[0]) - {40'h0, $past(src_tick[2])})
        else $error("wrong clock source");
    c_expiry:   cover property (@(posedge pclk) disable iff (!presetn) tmr_irq[0]);
    c_wake:     cover property (@(posedge pclk) disable iff (!presetn) wake_req);
    c_cal_done: cover property (@(posedge pclk) disable iff (!presetn) cal_reg ##1 !cal_reg);
endmodule
`default_nettype wire

/* dv/tb_swt_top.sv */
/*
 * tb_swt_top: self-checking bench for the wakeup timer block, driven over apb.
 * assumes: swt_pkg offsets and fields; the three 32 kHz sources are made here
 * at distinct rates so the selected source shows in the expiry time.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_swt_top;
    import swt_pkg::*;
    localparam int RC_HALF = 500000000 / SWT_RC_HZ;
    logic        pclk            = 1'b0;
    logic        presetn         = 1'b0;
    logic        psel            = 1'b0;
    logic        penable         = 1'b0;
    logic        pwrite          = 1'b0;
    logic [7:0]  paddr           = 8'h00;
    logic [31:0] pwdata          = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        clk32_rc        = 1'b0;
    logic        clk32_xtal      = 1'b0;
    logic        clk32_ext       = 1'b0;
    logic [1:0]  pwr_state       = 2'h0;
    logic [1:0]  tmr_irq;
    logic        wake_req;
    int          num_errors      = 0;
    int          samples_checked = 0;
    int          per_ns [3]      = '{2 * RC_HALF, 28572, 25000};

    always #50 pclk = ~pclk;
    always #RC_HALF clk32_rc = ~clk32_rc;
    always #14286 clk32_xtal = ~clk32_xtal;
    always #12500 clk32_ext = ~clk32_ext;

    swt_top i_swt_top (
        .pclk       (pclk),
        .presetn    (presetn),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .clk32_rc   (clk32_rc),
        .clk32_xtal (clk32_xtal),
        .clk32_ext  (clk32_ext),
        .pwr_state  (pwr_state),
        .tmr_irq    (tmr_irq),
        .wake_req   (wake_req)
    );

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held until pready is sampled high; released only at that edge
    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                            output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("unexpected apb timeout at %h", a);
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic        e;
        apb_xfer(1'b1, a, d, x, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb_xfer(1'b0, a, 32'h0, d, e);
    endtask

    // an observation window of up to lim cycles, ended by the first event; must=1 turns a missing event into a failure
    task automatic wait_evt(input int idx, input int lim, input bit must, output int cyc, output logic wk);
        cyc = -1;
        wk = 1'b0;
        for (int n = 1; n <= lim && cyc < 0; n++) begin
            @(posedge pclk);
            if (tmr_irq[idx] === 1'b1) begin
                cyc = n;
                wk = wake_req;
            end
        end
        if (must && cyc < 0) begin
            num_errors++;
            $display("unexpected missing event on timer %0d", idx);
            wrap_up();
        end
    endtask

    // start is placed a fixed distance after a source edge so the span is 20 whole periods less the offset
    task automatic run_cal(input int s, output int refv);
        logic [31:0] d;
        wr(SWT_OFF_CTRL, 32'(s) << SWT_CTRL_SRC_LSB);
        wr(SWT_OFF_LOAD0_LO, 32'(SWT_CAL_PERIODS));
        if (s == 0) @(posedge clk32_rc);
        else @(posedge clk32_xtal);
        repeat (10) @(posedge pclk);
        wr(SWT_OFF_CMD, 32'h1 << SWT_CMD_CAL);
        rd(SWT_OFF_CALREF, d);
        check("ref cleared", 64'(d < 32'd16), 64'h1);
        d = 32'h10;
        for (int n = 0; n < 4000 && d[SWT_ST_CALBUSY] !== 1'b0; n++) begin
            rd(SWT_OFF_STATUS, d);
        end
        check("cal done", d[SWT_ST_CALBUSY], 1'b0);
        rd(SWT_OFF_CALREF, d);
        refv = int'(d);
        repeat (50) @(posedge pclk);
        rd(SWT_OFF_CALREF, d);
        check("ref hold", d, 32'(refv));
    endtask

    initial begin
        repeat (100000) @(posedge pclk);
        num_errors++;
        $display("unexpected run length");
        wrap_up();
    end

    initial begin
        logic [31:0] d;
        logic [31:0] h;
        logic        e;
        logic        wk;
        int          c;
        int          p;
        int          r0;
        int          r1;
        int          nom;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(SWT_OFF_CTRL, d);
        check("ctrl reset", d, SWT_CTRL_RESET);
        rd(SWT_OFF_STATUS, d);
        check("status reset", d, 32'h0);
        apb_xfer(1'b0, 8'h30, 32'h0, d, e);
        check("unmapped err", e, 1'b1);
        check("unmapped data", d, 32'h0);
        apb_xfer(1'b0, 8'h02, 32'h0, d, e);
        check("misaligned err", e, 1'b1);
        wr(SWT_OFF_STATUS, 32'hff);
        rd(SWT_OFF_STATUS, d);
        check("status read only", d, 32'h0);
        wr(SWT_OFF_CTRL, 32'hffff_ffff);
        rd(SWT_OFF_CTRL, d);
        check("ctrl mask", d, SWT_CTRL_MASK);
        for (int s = 0; s < 3; s++) begin
            p = per_ns[s] / 100;
            wr(SWT_OFF_CTRL, (32'(s) << SWT_CTRL_SRC_LSB) | 32'h1);
            wr(SWT_OFF_LOAD0_LO, 32'd12);
            wr(SWT_OFF_LOAD0_HI, 32'h0);
            wr(SWT_OFF_CMD, 32'h1 << SWT_CMD_START0);
            wait_evt(0, 13 * p + 20, 1'b1, c, wk);
            // bounds in ns: the rc and crystal periods are not whole pclk cycles
            check("expiry span", 64'(c * 100 >= 11 * per_ns[s] && c * 100 <= 12 * per_ns[s] + 800), 64'h1);
            check("wake while awake", wk, 1'b0);
            rd(SWT_OFF_STATUS, d);
            check("status expired", d, 32'h5);
            rd(SWT_OFF_STATUS, d);
            check("status cleared", d, 32'h1);
            repeat (2 * p) @(posedge pclk);
            wr(SWT_OFF_CMD, 32'h1 << SWT_CMD_STOP0);
            rd(SWT_OFF_CNT0_HI, h);
            check("wrap high", h, 32'h1ff);
            rd(SWT_OFF_CNT0_LO, d);
            check("wrap low", 64'(d >= 32'hffff_fff0), 64'h1);
            repeat (p + 10) @(posedge pclk);
            rd(SWT_OFF_CNT0_LO, h);
            check("stopped hold", h, d);
            rd(SWT_OFF_STATUS, d);
            check("status stopped", d, 32'h0);
        end
        // timer 0 expires with its interrupt masked while timer 1 is stopped early
        p = per_ns[0] / 100;
        wr(SWT_OFF_CTRL, 32'h2);
        wr(SWT_OFF_LOAD0_LO, 32'd2);
        wr(SWT_OFF_LOAD1_LO, 32'd3);
        wr(SWT_OFF_LOAD1_HI, 32'h0);
        wr(SWT_OFF_CMD, 32'h3);
        repeat (p + p / 2) @(posedge pclk);
        wr(SWT_OFF_CMD, 32'h1 << SWT_CMD_STOP1);
        rd(SWT_OFF_CNT1_LO, h);
        check("timer1 counted", 64'(h < 32'd3), 64'h1);
        wait_evt(0, 4 * p, 1'b0, c, wk);
        check("masked expiry", c, -1);
        rd(SWT_OFF_CNT1_LO, d);
        check("timer1 hold", d, h);
        rd(SWT_OFF_STATUS, d);
        check("status mixed", d, 32'h5);
        wr(SWT_OFF_CMD, 32'h1 << SWT_CMD_STOP0);
        // sleep, sleep with timers disabled, deep sleep, then awake again
        wr(SWT_OFF_CTRL, 32'h1);
        pwr_state <= SWT_PWR_SLEEP;
        wr(SWT_OFF_LOAD0_LO, 32'd3);
        wr(SWT_OFF_CMD, 32'h1 << SWT_CMD_START0);
        wait_evt(0, 4 * p + 20, 1'b1, c, wk);
        check("wake in sleep", wk, 1'b1);
        wr(SWT_OFF_CMD, 32'h1 << SWT_CMD_STOP0);
        wr(SWT_OFF_CTRL, 32'h5);
        wr(SWT_OFF_LOAD0_LO, 32'd2);
        wr(SWT_OFF_CMD, 32'h1 << SWT_CMD_START0);
        wait_evt(0, 4 * p, 1'b0, c, wk);
        check("sleep disabled", c, -1);
        rd(SWT_OFF_CNT0_LO, d);
        check("sleep disabled count", d, 32'd2);
        wr(SWT_OFF_CTRL, 32'h1);
        pwr_state <= SWT_PWR_DEEP;
        wait_evt(0, 4 * p, 1'b0, c, wk);
        check("deep sleep", c, -1);
        rd(SWT_OFF_CNT0_LO, d);
        check("deep sleep count", d, 32'd2);
        pwr_state <= SWT_PWR_AWAKE;
        wait_evt(0, 3 * p + 20, 1'b1, c, wk);
        check("no wake when awake", wk, 1'b0);
        wr(SWT_OFF_CMD, 32'h1 << SWT_CMD_STOP0);
        run_cal(0, r0);
        nom = per_ns[0] * SWT_CAL_PERIODS / 100;
        check("cal rc", 64'(r0 >= nom - 20 && r0 <= nom), 64'h1);
        run_cal(1, r1);
        nom = per_ns[1] * SWT_CAL_PERIODS / 100;
        check("cal fast", 64'(r1 >= nom - 20 && r1 <= nom), 64'h1);
        check("fast is less", 64'(r1 < r0), 64'h1);
        // software scales 12 nominal rc periods by the measured ratio and times them on timer 1 from the fast source
        c = (12 * r0 + r1 / 2) / r1;
        wr(SWT_OFF_CTRL, (32'(SWT_SRC_XTAL) << SWT_CTRL_SRC_LSB) | (32'h1 << SWT_CTRL_IEN1));
        wr(SWT_OFF_LOAD1_LO, 32'(c));
        wr(SWT_OFF_LOAD1_HI, 32'h0);
        wr(SWT_OFF_CMD, 32'h1 << SWT_CMD_START1);
        wait_evt(1, 13 * per_ns[0] / 100, 1'b1, c, wk);
        check("scaled sleep", 64'(c * 100 >= 12 * per_ns[0] - 2 * per_ns[1] && c * 100 <= 12 * per_ns[0] + per_ns[1]), 64'h1);
        check("timer1 no wake", wk, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
